/* File: hw/fls_regs.vh */
// constants for the fuse, lock and identity store
`ifndef FLS_REGS_VH
`define FLS_REGS_VH
`define FLS_ID_BYTE_0 2'h0
`define FLS_ID_BYTE_1 2'h1
`define FLS_ID_BYTE_2 2'h2
`define FLS_ID_VAL_0 8'h5a
`define FLS_ID_VAL_1 8'h3c
`define FLS_ID_VAL_2 8'h11
`define FLS_FUSE_HI_RST 8'h99
`define FLS_FUSE_LO_RST 8'he1
`define FLS_LOCK_RST 8'hff
`define FLS_CAL_1M 8'h80
`define FLS_CAL_2M 8'h81
`define FLS_CAL_4M 8'h82
`define FLS_CAL_8M 8'h83
`define FLS_FH_DEBUG 7
`define FLS_FH_SERIAL 5
`define FLS_FH_EEKEEP 3
`define FLS_FH_BOOTSZ_HI 2
`define FLS_FH_BOOTSZ_LO 1
`define FLS_LK_MAIN_LO 0
`define FLS_LK_BOOT_LO 4
`define FLS_LK_BOOT_HI 5
`define FLS_PG_WORD_MSB 5
`define FLS_PG_PAGE_LSB 6
`define FLS_PG_PAGE_MSB 13
`define FLS_EE_BYTE_MSB 1
`define FLS_EE_PAGE_LSB 2
`define FLS_EE_PAGE_MSB 9
`endif

/* File: hw/fls_store.v */
// fuse, lock bit, identity row and calibration store with boot-section guard
`timescale 1ns/1ns
`include "fls_regs.vh"

// Functional notes
// - boot lock bits 1,1: no limit on store or load accesses to boot section
// - boot lock modes 2 and 3 block program stores into boot section
// - modes 3 and 4 block loads from application code into boot section
// - modes 3 and 4 mask interrupts in boot code when vectors in application
// - fuse bits read zero when programmed, one when unprogrammed
// - eeprom-preserve fuse programmed keeps eeprom through chip erase
// - serial-program fuse neither readable nor writable in serial programming mode
// - chip erase leaves every fuse bit unchanged
// - programmed main lock bit low refuses all fuse changes
// - fuses captured on programming entry, changes effective on exit
// - eeprom-preserve fuse takes effect at once
// - normal mode captures fuses at power-up
// - boot size fuses default programmed, largest boot section
// - default clock source fuses select internal rc at 1 mhz
// - debug fuse programmed keeps clock parts running in sleep
// - three identity bytes readable in either mode even when locked
// - identity bytes in own space addressed by byte index
// - four calibration bytes in high byte of identity rows 0 to 3
// - 1 mhz calibration loaded into calibration register at reset
// - flash 256 pages of 64 words, word pc 5:0, page pc 13:6
// - eeprom 256 pages of 4 bytes, byte addr 1:0, page addr 9:2
// - lock bits return to unprogrammed only by chip erase or by SRST_I
module fls_store (
  input wire CLK_I,
  input wire SRST_I,
  input wire CE_I,
  input wire PROG_MODE_I,
  input wire SERIAL_MODE_I,
  input wire FUSE_WR_I,
  input wire FUSE_SEL_HI_I,
  input wire [7:0] FUSE_WDATA_I,
  input wire LOCK_WR_I,
  input wire [7:0] LOCK_WDATA_I,
  input wire CHIP_ERASE_I,
  input wire RD_I,
  input wire [1:0] RD_SPACE_I,
  input wire RD_HIGH_I,
  input wire [1:0] RD_INDEX_I,
  input wire CAL_WR_I,
  input wire [7:0] CAL_WDATA_I,
  input wire STORE_REQ_I,
  input wire LOAD_REQ_I,
  input wire [13:0] PC_TARGET_I,
  input wire EXEC_IN_BOOT_I,
  input wire [13:0] BOOT_START_I,
  input wire VEC_IN_APP_I,
  input wire [9:0] EE_ADDR_I,
  output reg [7:0] RDATA_O,
  output reg RVALID_O,
  output reg [7:0] FUSE_HI_ACT_O,
  output reg [7:0] FUSE_LO_ACT_O,
  output reg [7:0] LOCK_O,
  output reg [7:0] CAL_O,
  output reg EE_ERASE_O,
  output reg FLASH_ERASE_O,
  output reg STORE_OK_O,
  output reg LOAD_OK_O,
  output reg IRQ_MASK_O,
  output reg SLEEP_CLK_KEEP_O,
  output reg [5:0] FL_WORD_O,
  output reg [7:0] FL_PAGE_O,
  output reg [1:0] EE_BYTE_O,
  output reg [7:0] EE_PAGE_O
);

  // ****************************************
  // input synchronisers
  // ****************************************
  wire prog_s2_q;
  wire ser_s2_q;
  reg prog_prev_q;

  fls_sync prog_sync_u (
    .clk_i(CLK_I),
    .srst_i(SRST_I),
    .ce_i(CE_I),
    .d_i(PROG_MODE_I),
    .q_o(prog_s2_q)
  );

  fls_sync ser_sync_u (
    .clk_i(CLK_I),
    .srst_i(SRST_I),
    .ce_i(CE_I),
    .d_i(SERIAL_MODE_I),
    .q_o(ser_s2_q)
  );

  // previous synced mode, for entry and exit edges
  always @(posedge CLK_I) begin
    if (SRST_I) begin
      prog_prev_q <= 1'b0;
    end else if (CE_I) begin
      prog_prev_q <= prog_s2_q;
    end
  end

  wire prog_entry = prog_s2_q & ~prog_prev_q;
  wire prog_exit = ~prog_s2_q & prog_prev_q;
  wire serial_prog = prog_s2_q & ser_s2_q;

  // ****************************************
  // fuse and lock storage
  // ****************************************
  reg [7:0] fuse_hi_q;
  reg [7:0] fuse_lo_q;
  reg [7:0] lock_q;
  reg [7:0] lock_d;
  reg [7:0] fuse_hi_d;
  wire fuse_locked = ~lock_q[`FLS_LK_MAIN_LO];

  always @* begin
    fuse_hi_d = FUSE_WDATA_I;
    if (serial_prog) begin
      fuse_hi_d[`FLS_FH_SERIAL] = fuse_hi_q[`FLS_FH_SERIAL];
    end
  end

  always @* begin
    lock_d = lock_q;
    if (CHIP_ERASE_I) begin
      lock_d = `FLS_LOCK_RST;
    end else if (LOCK_WR_I) begin
      lock_d = lock_q & LOCK_WDATA_I;
    end
    // unused lock bits always read unprogrammed
    lock_d[7:6] = 2'h3;
  end

  always @(posedge CLK_I) begin
    if (SRST_I) begin
      fuse_hi_q <= `FLS_FUSE_HI_RST;
      fuse_lo_q <= `FLS_FUSE_LO_RST;
      lock_q <= `FLS_LOCK_RST;
    end else if (CE_I && prog_s2_q) begin
      lock_q <= lock_d;
      if (FUSE_WR_I && !fuse_locked && !CHIP_ERASE_I) begin
        if (FUSE_SEL_HI_I) begin
          fuse_hi_q <= fuse_hi_d;
        end else begin
          fuse_lo_q <= FUSE_WDATA_I;
        end
      end
    end
  end

  // ****************************************
  // latched fuse copies seen by the chip
  // ****************************************
  reg pwr_up_q;

  always @(posedge CLK_I) begin
    if (SRST_I) begin
      pwr_up_q <= 1'b1;
      FUSE_HI_ACT_O <= `FLS_FUSE_HI_RST;
      FUSE_LO_ACT_O <= `FLS_FUSE_LO_RST;
      SLEEP_CLK_KEEP_O <= 1'b0;
    end else if (CE_I) begin
      pwr_up_q <= 1'b0;
      if (pwr_up_q || prog_entry || prog_exit) begin
        FUSE_HI_ACT_O <= fuse_hi_q;
        FUSE_LO_ACT_O <= fuse_lo_q;
      end else begin
        FUSE_HI_ACT_O[`FLS_FH_EEKEEP] <= fuse_hi_q[`FLS_FH_EEKEEP];
      end
      SLEEP_CLK_KEEP_O <= ~FUSE_HI_ACT_O[`FLS_FH_DEBUG];
    end
  end

  // ****************************************
  // chip erase effects
  // ****************************************
  always @(posedge CLK_I) begin
    if (SRST_I) begin
      EE_ERASE_O <= 1'b0;
      FLASH_ERASE_O <= 1'b0;
    end else if (CE_I) begin
      FLASH_ERASE_O <= CHIP_ERASE_I & prog_s2_q;
      EE_ERASE_O <= CHIP_ERASE_I & prog_s2_q & fuse_hi_q[`FLS_FH_EEKEEP];
    end
  end

  // ****************************************
  // calibration register
  // ****************************************
  always @(posedge CLK_I) begin
    if (SRST_I) begin
      CAL_O <= `FLS_CAL_1M;
    end else if (CE_I && CAL_WR_I) begin
      CAL_O <= CAL_WDATA_I;
    end
  end

  // ****************************************
  // read port: identity row, fuses, locks
  // ****************************************
  reg [7:0] rd_d;

  always @* begin
    rd_d = 8'h00;
    case (RD_SPACE_I)
      2'h0: begin
        if (RD_HIGH_I) begin
          case (RD_INDEX_I)
            2'h0: rd_d = `FLS_CAL_1M;
            2'h1: rd_d = `FLS_CAL_2M;
            2'h2: rd_d = `FLS_CAL_4M;
            default: rd_d = `FLS_CAL_8M;
          endcase
        end else begin
          case (RD_INDEX_I)
            `FLS_ID_BYTE_0: rd_d = `FLS_ID_VAL_0;
            `FLS_ID_BYTE_1: rd_d = `FLS_ID_VAL_1;
            `FLS_ID_BYTE_2: rd_d = `FLS_ID_VAL_2;
            default: rd_d = 8'h00;
          endcase
        end
      end
      2'h1: begin
        rd_d = fuse_hi_q;
        if (serial_prog) begin
          rd_d[`FLS_FH_SERIAL] = 1'b0;
        end
      end
      2'h2: rd_d = fuse_lo_q;
      default: rd_d = lock_q;
    endcase
  end

  always @(posedge CLK_I) begin
    if (SRST_I) begin
      RDATA_O <= 8'h00;
      RVALID_O <= 1'b0;
      LOCK_O <= `FLS_LOCK_RST;
    end else if (CE_I) begin
      RVALID_O <= RD_I;
      if (RD_I) begin
        RDATA_O <= rd_d;
      end
      LOCK_O <= lock_q;
    end
  end

  // ****************************************
  // boot section guard and page geometry
  // ****************************************
  wire [1:0] boot_mode = {lock_q[`FLS_LK_BOOT_HI], lock_q[`FLS_LK_BOOT_LO]};
  wire in_boot = PC_TARGET_I >= BOOT_START_I;
  wire no_store = (boot_mode == 2'h2) || (boot_mode == 2'h0);
  wire no_load = ~boot_mode[1];

  always @(posedge CLK_I) begin
    if (SRST_I) begin
      STORE_OK_O <= 1'b0;
      LOAD_OK_O <= 1'b0;
      IRQ_MASK_O <= 1'b0;
      FL_WORD_O <= 6'h00;
      FL_PAGE_O <= 8'h00;
      EE_BYTE_O <= 2'h0;
      EE_PAGE_O <= 8'h00;
    end else if (CE_I) begin
      STORE_OK_O <= STORE_REQ_I & ~(in_boot & no_store);
      LOAD_OK_O <= LOAD_REQ_I & ~(in_boot & ~EXEC_IN_BOOT_I & no_load);
      IRQ_MASK_O <= no_load & VEC_IN_APP_I & EXEC_IN_BOOT_I;
      FL_WORD_O <= PC_TARGET_I[`FLS_PG_WORD_MSB:0];
      FL_PAGE_O <= PC_TARGET_I[`FLS_PG_PAGE_MSB:`FLS_PG_PAGE_LSB];
      EE_BYTE_O <= EE_ADDR_I[`FLS_EE_BYTE_MSB:0];
      EE_PAGE_O <= EE_ADDR_I[`FLS_EE_PAGE_MSB:`FLS_EE_PAGE_LSB];
    end
  end

endmodule

// ****************************************
// two-stage synchroniser for pin inputs
// ****************************************
module fls_sync (
  input wire clk_i,
  input wire srst_i,
  input wire ce_i,
  input wire d_i,
  output reg q_o
);

  // only the second stage is read outside this module
  reg meta_q;

  always @(posedge clk_i) begin
    if (srst_i) begin
      meta_q <= 1'b0;
      q_o <= 1'b0;
    end else if (ce_i) begin
      meta_q <= d_i;
      q_o <= meta_q;
    end
  end

endmodule

/* File: bench/fls_store_asserts.sv */
// port assertions for the fuse, lock and identity store
`timescale 1ns/1ns
`include "fls_regs.vh"
module fls_chk (
  input wire CLK_I, SRST_I, RD_I, RD_HIGH_I, SERIAL_MODE_I, STORE_REQ_I, LOAD_REQ_I,
  input wire EXEC_IN_BOOT_I, VEC_IN_APP_I, CHIP_ERASE_I,
  input wire PROG_MODE_I,
  input wire [1:0] RD_SPACE_I, RD_INDEX_I,
  input wire [13:0] PC_TARGET_I, BOOT_START_I,
  input wire [9:0] EE_ADDR_I,
  input wire [7:0] RDATA_O, LOCK_O, CAL_O, FUSE_HI_ACT_O, FL_PAGE_O, EE_PAGE_O,
  input wire RVALID_O, EE_ERASE_O, FLASH_ERASE_O, STORE_OK_O, LOAD_OK_O, IRQ_MASK_O,
  input wire [5:0] FL_WORD_O,
  input wire [1:0] EE_BYTE_O
);
  // ***********
  // properties
  // ***********
  default clocking @(posedge CLK_I); endclocking
  default disable iff (SRST_I);
  wire boot_w = PC_TARGET_I >= BOOT_START_I;
  sequence id0_ans;
    RVALID_O && RDATA_O == `FLS_ID_VAL_0;
  endsequence
  fl_index_a: assert property (1'b1 |=> FL_WORD_O == $past(PC_TARGET_I[5:0]) &&
    FL_PAGE_O == $past(PC_TARGET_I[13:6])) else $error("flash index");
  ee_index_a: assert property (1'b1 |=> EE_BYTE_O == $past(EE_ADDR_I[1:0]) &&
    EE_PAGE_O == $past(EE_ADDR_I[9:2])) else $error("eeprom index");
  store_free_a: assert property (STORE_REQ_I && boot_w
    |=> LOCK_O[5:4] != 2'h3 || STORE_OK_O) else $error("store refused");
  store_block_a: assert property (STORE_REQ_I && boot_w
    |=> LOCK_O[4] || !STORE_OK_O) else $error("store granted");
  load_block_a: assert property (LOAD_REQ_I && boot_w && !EXEC_IN_BOOT_I
    |=> LOCK_O[5] || !LOAD_OK_O) else $error("load granted");
  irq_mask_a: assert property (EXEC_IN_BOOT_I && VEC_IN_APP_I
    |=> LOCK_O[5] || IRQ_MASK_O) else $error("irq not masked");
  ee_keep_a: assert property (FLASH_ERASE_O |-> EE_ERASE_O == FUSE_HI_ACT_O[3])
    else $error("eeprom erase");
  serial_hide_a: assert property (RD_I && RD_SPACE_I == 2'h1 && SERIAL_MODE_I &&
    $past(SERIAL_MODE_I, 4) && PROG_MODE_I && $past(PROG_MODE_I, 4)
    |=> !RDATA_O[5]) else $error("serial fuse seen");
  cal_load_a: assert property ($fell(SRST_I) |-> CAL_O == `FLS_CAL_1M)
    else $error("calibration");
  lock_keep_a: assert property (!CHIP_ERASE_I && !$past(CHIP_ERASE_I)
    |=> (LOCK_O & ~$past(LOCK_O)) == 8'h00)
    else $error("lock released");
  id_read_a: assert property (RD_I && RD_SPACE_I == 2'h0 && !RD_HIGH_I &&
    RD_INDEX_I == 2'h0 |=> id0_ans) else $error("identity");
endmodule

/* File: bench/fls_prog_model.sv */
// external programmer model driving fuse, lock and erase requests
`timescale 1ns/1ns
module fls_prog_model (
  input wire clk_i,
  output reg prog_o, serial_o, fuse_wr_o, fuse_hi_o, lock_wr_o, erase_o,
  output reg [7:0] fuse_d_o, lock_d_o
);
  initial {prog_o, serial_o, fuse_wr_o, fuse_hi_o, lock_wr_o, erase_o} = 6'h00;
  initial {fuse_d_o, lock_d_o} = 16'h0000;
  // one-cycle request, data inverted once released
  task pulse(input integer k, input [7:0] d, input hi);
    @(negedge clk_i);
    fuse_hi_o = hi;
    {fuse_d_o, lock_d_o} = {d, d};
    if (k == 0) fuse_wr_o = 1'b1;
    else if (k == 1) lock_wr_o = 1'b1;
    else erase_o = 1'b1;
    @(negedge clk_i);
    {fuse_wr_o, lock_wr_o, erase_o} = 3'h0;
    {fuse_d_o, lock_d_o} = {~d, ~d};
  endtask
  task mode(input p, input s);
    @(negedge clk_i);
    {prog_o, serial_o} = {p, s};
    repeat (5) @(negedge clk_i);
  endtask
endmodule

/* File: bench/fls_store_test.sv */
// self-checking bench for the fuse, lock and identity store
`timescale 1ns/1ns
`include "fls_regs.vh"
module fls_store_test;
  reg clk = 0, srst = 1, rd = 0, rh = 0, sreq = 0, lreq = 0, boot = 0, vec = 0;
  reg [1:0] sp = 0, ix = 0;
  reg [13:0] pc = 0, bs = 0;
  reg [9:0] ea = 0;
  integer n_fail = 0, compares = 0, seed = 32'h0fd9, i;
  wire pm, sm, fw, fsh, lw, ce, rv, eee, fle, sok, lok, irq, skp;
  wire [7:0] fwd, lwd, rdat, fha, fla, lk, cal, flp, eep;
  wire [5:0] flw;
  wire [1:0] eeb;
  initial forever #50 clk = ~clk;
  fls_prog_model prog_u (.clk_i(clk), .prog_o(pm), .serial_o(sm), .fuse_wr_o(fw),
    .fuse_hi_o(fsh), .lock_wr_o(lw), .erase_o(ce), .fuse_d_o(fwd), .lock_d_o(lwd));
  fls_store dut_u (.CLK_I(clk), .SRST_I(srst), .CE_I(1'b1), .PROG_MODE_I(pm),
    .SERIAL_MODE_I(sm), .FUSE_WR_I(fw), .FUSE_SEL_HI_I(fsh), .FUSE_WDATA_I(fwd),
    .LOCK_WR_I(lw), .LOCK_WDATA_I(lwd), .CHIP_ERASE_I(ce), .RD_I(rd), .RD_SPACE_I(sp),
    .RD_HIGH_I(rh), .RD_INDEX_I(ix), .CAL_WR_I(1'b0), .CAL_WDATA_I(8'h00),
    .STORE_REQ_I(sreq), .LOAD_REQ_I(lreq), .PC_TARGET_I(pc), .EXEC_IN_BOOT_I(boot),
    .BOOT_START_I(bs), .VEC_IN_APP_I(vec), .EE_ADDR_I(ea), .RDATA_O(rdat), .RVALID_O(rv),
    .FUSE_HI_ACT_O(fha), .FUSE_LO_ACT_O(fla), .LOCK_O(lk), .CAL_O(cal), .EE_ERASE_O(eee),
    .FLASH_ERASE_O(fle), .STORE_OK_O(sok), .LOAD_OK_O(lok), .IRQ_MASK_O(irq),
    .SLEEP_CLK_KEEP_O(skp), .FL_WORD_O(flw), .FL_PAGE_O(flp), .EE_BYTE_O(eeb),
    .EE_PAGE_O(eep));
  function [7:0] row(input h, input [1:0] x);
    if (h) row = x == 0 ? `FLS_CAL_1M : x == 1 ? `FLS_CAL_2M : x == 2 ? `FLS_CAL_4M : `FLS_CAL_8M;
    else row = x == 0 ? `FLS_ID_VAL_0 : x == 1 ? `FLS_ID_VAL_1 : `FLS_ID_VAL_2;
  endfunction
  task check(input [7:0] got, input [7:0] exp);
    compares = compares + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task read(input [1:0] s, input h, input [1:0] x, input [7:0] exp);
    @(negedge clk);
    {rd, sp, rh, ix} = {1'b1, s, h, x};
    @(negedge clk);
    {rd, sp} = {1'b0, ~s};
    check(rv ? rdat : 8'hxx, exp);
  endtask
  task rnd(input [7:0] n);
    repeat (n) begin
      @(negedge clk);
      {pc, ea, bs} = {$random(seed), $random(seed)};
      {sreq, lreq, boot, vec} = $random(seed);
      @(negedge clk);
      check(flp, pc[13:6]);
      check(eep, ea[9:2]);
    end
  endtask
  task finish_test;
    if (n_fail == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge clk);
    srst = 0;
    for (i = 0; i < 4; i = i + 1) begin
      if (i < 3) read(0, 0, i, row(0, i));
      read(0, 1, i, row(1, i));
    end
    check(cal, `FLS_CAL_1M);
    read(1, 0, 0, 8'h99);
    read(2, 0, 0, 8'he1);
    check(fha, 8'h99);
    rnd(40);
    prog_u.mode(1, 0);
    prog_u.pulse(2, 8'h00, 0);
    check({6'h0, fle, eee}, 8'h03);
    prog_u.pulse(0, 8'h30, 1);
    @(negedge clk);
    check(fha, 8'h91);
    prog_u.pulse(2, 8'h00, 0);
    check({6'h0, fle, eee}, 8'h02);
    read(1, 0, 0, 8'h30);
    prog_u.pulse(1, 8'hce, 0);
    prog_u.pulse(0, 8'h00, 0);
    read(2, 0, 0, 8'he1);
    prog_u.mode(0, 0);
    check(fha, 8'h30);
    check({7'h0, skp}, 8'h01);
    rnd(40);
    prog_u.mode(1, 1);
    read(1, 0, 0, 8'h10);
    prog_u.pulse(2, 8'h00, 0);
    read(3, 0, 0, 8'hff);
    finish_test;
  end
endmodule
bind fls_store fls_chk chk_u (.*);
